// ### include/adcpc_pkg.sv
package adcpc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NPINS = 24;
    localparam int RAW_W = 12;
    // register offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h1;
    localparam logic [3:0] OFS_CFG = 4'h2;
    localparam logic [3:0] OFS_RES_HI = 4'h3;
    localparam logic [3:0] OFS_RES_LO = 4'h4;
    localparam logic [3:0] OFS_CMP_HI = 4'h5;
    localparam logic [3:0] OFS_CMP_LO = 4'h6;
    localparam logic [3:0] OFS_PIN_LO = 4'h7;
    localparam logic [3:0] OFS_PIN_MID = 4'h8;
    localparam logic [3:0] OFS_PIN_HI = 4'h9;
    // control fields
    localparam int CTL_CMP_EN = 5;
    localparam int CTL_IRQ_EN = 6;
    localparam int CTL_CMP_GT = 7;
    localparam logic [4:0] CH_OFF = 5'h1F;
    // configuration fields
    localparam int CFG_CLK_LO = 0;
    localparam int CFG_MODE_LO = 2;
    localparam int CFG_DIV_LO = 5;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h1F;
    localparam logic [7:0] PIN_RST = 8'h00;
    // input clock select codes
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_BUS2 = 2'h1;
    localparam logic [1:0] CLK_ALT = 2'h2;
    localparam logic [1:0] CLK_ASYNC = 2'h3;
    // conversion modes
    localparam logic [1:0] MODE_8 = 2'h0;
    localparam logic [1:0] MODE_12 = 2'h1;
    localparam logic [1:0] MODE_10 = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_STORE} adcpc_state_type;
    // pad side bundle
    typedef struct packed {
        logic [NPINS-1:0] out;
        logic [NPINS-1:0] oe;
        logic [NPINS-1:0] pull_en;
    } adcpc_pin_type;
endpackage : adcpc_pkg

// ### hw/adcpc_top.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module adcpc_top
    import adcpc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // general port logic requests and pad
    input wire adcpc_pin_type i_port_req,
    input wire logic [NPINS-1:0] i_pad_in,
    output adcpc_pin_type o_pad,
    output logic [NPINS-1:0] o_port_in,
    // clock sources, sampled as synchronous levels
    input wire logic i_alt_clk,
    input wire logic i_async_clk,
    // analog core
    input wire logic i_conv_done,
    input wire logic [RAW_W-1:0] i_conv_raw,
    output logic o_conv_start,
    output logic o_conv_tick,
    output logic o_conv_active,
    output logic o_async_osc_en,
    output logic [4:0] o_channel,
    output logic [1:0] o_mode,
    output logic o_irq
);
    // register state
    logic [7:0] ctrl_r, ctrl_nxt, cfg_r, cfg_nxt;
    logic [7:0] cmp_hi_r, cmp_hi_nxt, cmp_lo_r, cmp_lo_nxt;
    logic [7:0] res_hi_r, res_hi_nxt, res_lo_r, res_lo_nxt;
    logic [NPINS-1:0] pin_r, pin_nxt;
    logic done_flag_r, done_flag_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    adcpc_state_type state_r, state_nxt;
    logic start_r, start_nxt, irq_r, irq_nxt;
    logic [11:0] raw_r, raw_nxt;
    logic [1:0] clk_sel, div_sel, mode;
    logic ch_off, go;
    assign clk_sel = cfg_r[CFG_CLK_LO +: 2];
    assign div_sel = cfg_r[CFG_DIV_LO +: 2];
    assign mode = cfg_r[CFG_MODE_LO +: 2];
    assign ch_off = (ctrl_r[4:0] == CH_OFF);
    // a control write with a live channel launches a conversion
    assign go = i_wr && (i_addr == OFS_CTRL) && (i_wdata[4:0] != CH_OFF);

    // rounding and compare of the stored value
    logic [12:0] sum10;
    logic [9:0] sum8;
    logic [11:0] fmt, cmp_val;
    logic cmp_hit, store_ok;
    always_comb begin
        sum10 = {1'b0, raw_r} + 13'h0002;
        sum8 = {1'b0, raw_r[8:0]} + 10'h001;
        cmp_val = {cmp_hi_r[3:0], cmp_lo_r};
        unique case (mode)
            MODE_12: begin
                fmt = raw_r;
            end
            MODE_10: begin
                // round half up, saturate at full scale
                fmt = sum10[12] ? 12'h3FF : {2'h0, sum10[11:2]};
                cmp_val = {2'h0, cmp_hi_r[1:0], cmp_lo_r};
            end
            default: begin
                fmt = sum8[9] ? 12'h0FF : {4'h0, sum8[8:1]};
                cmp_val = {4'h0, cmp_lo_r};
            end
        endcase
        cmp_hit = ctrl_r[CTL_CMP_GT] ? (fmt >= cmp_val) : (fmt < cmp_val);
        store_ok = !ctrl_r[CTL_CMP_EN] || cmp_hit;
    end

    // conversion sequencer; idles between conversions unless a control write starts one in the store cycle
    always_comb begin
        state_nxt = state_r;
        start_nxt = 1'b0;
        raw_nxt = raw_r;
        unique case (state_r)
            ST_IDLE: begin
                if (go) begin
                    state_nxt = ST_CONV;
                    start_nxt = 1'b1;
                end
            end
            ST_CONV: begin
                if (go) begin
                    start_nxt = 1'b1;
                end else if (ch_off) begin
                    state_nxt = ST_IDLE;
                end else if (i_conv_done) begin
                    raw_nxt = i_conv_raw;
                    state_nxt = ST_STORE;
                end
            end
            ST_STORE: begin
                state_nxt = ST_IDLE;
                if (go) begin
                    state_nxt = ST_CONV;
                    start_nxt = 1'b1;
                end
            end
        endcase
    end

    // register writes, result store and flag
    always_comb begin
        ctrl_nxt = ctrl_r;
        cfg_nxt = cfg_r;
        cmp_hi_nxt = cmp_hi_r;
        cmp_lo_nxt = cmp_lo_r;
        pin_nxt = pin_r;
        res_hi_nxt = res_hi_r;
        res_lo_nxt = res_lo_r;
        done_flag_nxt = done_flag_r;
        if (i_wr) begin
            unique case (i_addr)
                OFS_CTRL: begin
                    ctrl_nxt = i_wdata;
                    done_flag_nxt = 1'b0;
                end
                OFS_CFG: cfg_nxt = i_wdata;
                OFS_CMP_HI: cmp_hi_nxt = i_wdata;
                OFS_CMP_LO: cmp_lo_nxt = i_wdata;
                OFS_PIN_LO: pin_nxt[7:0] = i_wdata;
                OFS_PIN_MID: pin_nxt[15:8] = i_wdata;
                OFS_PIN_HI: pin_nxt[23:16] = i_wdata;
                default: ;
            endcase
        end
        // reading the low result acknowledges the completion
        if (i_rd && (i_addr == OFS_RES_LO)) begin
            done_flag_nxt = 1'b0;
        end
        // store wins over a clear in the same cycle
        if ((state_r == ST_STORE) && store_ok) begin
            res_lo_nxt = fmt[7:0];
            res_hi_nxt = (mode == MODE_8) ? 8'h00 : {4'h0, fmt[11:8]};
            done_flag_nxt = 1'b1;
        end
    end

    // read mux, data one cycle after the strobe
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                OFS_CTRL: rdata_nxt = ctrl_r;
                OFS_STAT: rdata_nxt = {6'h00, state_r != ST_IDLE, done_flag_r};
                OFS_CFG: rdata_nxt = cfg_r;
                OFS_RES_HI: rdata_nxt = res_hi_r;
                OFS_RES_LO: rdata_nxt = res_lo_r;
                OFS_CMP_HI: rdata_nxt = cmp_hi_r;
                OFS_CMP_LO: rdata_nxt = cmp_lo_r;
                OFS_PIN_LO: rdata_nxt = pin_r[7:0];
                OFS_PIN_MID: rdata_nxt = pin_r[15:8];
                OFS_PIN_HI: rdata_nxt = pin_r[23:16];
                default: rdata_nxt = 8'h00;
            endcase
        end
        irq_nxt = done_flag_nxt && ctrl_nxt[CTL_IRQ_EN];
    end

    // per-pin handover from port logic to the analog channel
    adcpc_pin_type pad_nxt;
    logic [NPINS-1:0] port_in_nxt;
    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            // bit g of the 24-bit claim vector is channel g
            assign pad_nxt.out[g] = i_port_req.out[g] & ~pin_r[g];
            assign pad_nxt.oe[g] = i_port_req.oe[g] & ~pin_r[g];
            assign pad_nxt.pull_en[g] = i_port_req.pull_en[g] & ~pin_r[g];
            assign port_in_nxt[g] = i_pad_in[g] & ~pin_r[g];
        end
    endgenerate

    // conversion clock: source tick then divider
    logic bus2_r, bus2_nxt, alt_q_r, alt_q_nxt, asy_q_r, asy_q_nxt;
    logic [2:0] div_cnt_r, div_cnt_nxt;
    logic [2:0] div_max;
    logic src_tick, tick_nxt, active_nxt, osc_nxt;
    always_comb begin
        bus2_nxt = ~bus2_r;
        alt_q_nxt = i_alt_clk;
        asy_q_nxt = i_async_clk;
        unique case (clk_sel)
            CLK_BUS: src_tick = 1'b1;
            CLK_BUS2: src_tick = bus2_r;
            CLK_ALT: src_tick = i_alt_clk & ~alt_q_r;
            CLK_ASYNC: src_tick = i_async_clk & ~asy_q_r;
        endcase
        unique case (div_sel)
            2'h0: div_max = 3'h0;
            2'h1: div_max = 3'h1;
            2'h2: div_max = 3'h3;
            2'h3: div_max = 3'h7;
        endcase
        div_cnt_nxt = div_cnt_r;
        tick_nxt = 1'b0;
        if (src_tick) begin
            if (div_cnt_r >= div_max) begin
                div_cnt_nxt = 3'h0;
                tick_nxt = (state_r != ST_IDLE);
            end else begin
                div_cnt_nxt = div_cnt_r + 3'h1;
            end
        end
        active_nxt = (state_nxt != ST_IDLE);
        // wait or stop3 does not gate this enable
        osc_nxt = active_nxt && (cfg_nxt[CFG_CLK_LO +: 2] == CLK_ASYNC);
    end

    // registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= CTRL_RST;
            cfg_r <= CFG_RST;
            cmp_hi_r <= 8'h00;
            cmp_lo_r <= 8'h00;
            pin_r <= {NPINS{1'b0}};
            res_hi_r <= 8'h00;
            res_lo_r <= 8'h00;
            done_flag_r <= 1'b0;
            rdata_r <= 8'h00;
            state_r <= ST_IDLE;
            start_r <= 1'b0;
            irq_r <= 1'b0;
            raw_r <= 12'h000;
            o_pad <= '0;
            o_port_in <= {NPINS{1'b0}};
            bus2_r <= 1'b0;
            alt_q_r <= 1'b0;
            asy_q_r <= 1'b0;
            div_cnt_r <= 3'h0;
            o_conv_tick <= 1'b0;
            o_conv_active <= 1'b0;
            o_async_osc_en <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cfg_r <= cfg_nxt;
            cmp_hi_r <= cmp_hi_nxt;
            cmp_lo_r <= cmp_lo_nxt;
            pin_r <= pin_nxt;
            res_hi_r <= res_hi_nxt;
            res_lo_r <= res_lo_nxt;
            done_flag_r <= done_flag_nxt;
            rdata_r <= rdata_nxt;
            state_r <= state_nxt;
            start_r <= start_nxt;
            irq_r <= irq_nxt;
            raw_r <= raw_nxt;
            o_pad <= pad_nxt;
            o_port_in <= port_in_nxt;
            bus2_r <= bus2_nxt;
            alt_q_r <= alt_q_nxt;
            asy_q_r <= asy_q_nxt;
            div_cnt_r <= div_cnt_nxt;
            o_conv_tick <= tick_nxt;
            o_conv_active <= active_nxt;
            o_async_osc_en <= osc_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_conv_start = start_r;
    assign o_irq = irq_r;
    assign o_channel = ctrl_r[4:0];
    assign o_mode = mode;

    // checks
    AST_PIN_OE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ##1 $past(pin_r[0]) |-> !o_pad.oe[0]) else $error("claimed pin driven");
    AST_PIN_IN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ##1 $past(pin_r[23]) |-> !o_port_in[23]) else $error("claimed pin read");
    AST_PIN_PULL: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ##1 $past(pin_r[8]) |-> !o_pad.pull_en[8]) else $error("claimed pin pulled");
    AST_PIN_MID: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr && i_addr == OFS_PIN_MID |=> pin_r[15:8] == $past(i_wdata))
        else $error("mid pin register wrong");
    AST_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ch_off && !go |=> !start_r) else $error("start while disabled");
    // a new start right after the store is legal, so both idle cycles need no start
    AST_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_r == ST_STORE && !go ##1 !go |-> !o_conv_active [*2])
        else $error("not idle after store");
    AST_RND10: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_r == ST_STORE && store_ok && mode == MODE_10 && raw_r == 12'h006
        |=> res_lo_r == 8'h02 && res_hi_r == 8'h00) else $error("10-bit rounding");
    AST_MODE8: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_r == ST_STORE && store_ok && mode == MODE_8 |=> res_hi_r == 8'h00)
        else $error("8-bit wrote high");
    AST_FLAG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_r == ST_STORE && store_ok |=> done_flag_r ##1 (irq_r == ctrl_r[CTL_IRQ_EN] || !done_flag_r))
        else $error("flag or irq wrong");
    AST_CMP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_r == ST_STORE && !ctrl_r[CTL_CMP_EN] |=> done_flag_r)
        else $error("store gated without compare");
    AST_DIV16: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_conv_tick) && clk_sel == CLK_BUS2 && div_sel == 2'h3 && $stable(cfg_r)
        |=> !o_conv_tick [*8]) else $error("divide by 16 broken");
    AST_ASYNC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_conv_active && clk_sel == CLK_ASYNC |-> o_async_osc_en)
        else $error("async oscillator off");
    COV_STORE: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        state_r == ST_STORE && store_ok);
    COV_CMP_MISS: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        state_r == ST_STORE && !store_ok);
    COV_PIN_CLAIM: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        pin_r[16] && i_port_req.oe[16]);
    COV_IRQ: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_irq));
endmodule : adcpc_top
`default_nettype wire

// ### verification/adcpc_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcpc_port_model
    import adcpc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // port logic requests and pad levels
    output adcpc_pin_type o_port_req,
    output logic [NPINS-1:0] o_pad_in,
    // slow clock sources, far below half the bus rate
    output logic o_alt_clk,
    output logic o_async_clk
);
    integer seed = 74;
    logic [95:0] rnd;
    logic [2:0] cnt;
    initial begin
        o_port_req = '0;
        o_pad_in = '0;
        cnt = 3'h0;
        o_alt_clk = 1'b0;
        o_async_clk = 1'b0;
    end
    // fresh values every cycle so a stale copy in the block never matches
    always @(posedge i_clk) begin
        rnd = {$random(seed), $random(seed), $random(seed)};
        o_port_req <= i_rst_n ? rnd[71:0] : '0;
        o_pad_in <= rnd[95:72];
        cnt <= cnt + 3'h1;
        o_alt_clk <= cnt[1]; // period of four bus cycles
        o_async_clk <= cnt[2]; // period of eight bus cycles
    end
endmodule : adcpc_port_model
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adcpc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic done = 1'b0;
    logic [11:0] raw = 12'h000;
    logic [7:0] rdata;
    adcpc_pin_type req, pad;
    logic [23:0] pad_in, port_in;
    logic alt, asy, start, tick, active, osc_en, irq;
    logic [4:0] chan;
    logic [1:0] mode;
    logic rd_seen = 1'b0;
    logic [11:0] exp_q[$];
    logic [11:0] e;
    logic [7:0] last_hi, last_lo;
    logic [23:0] pats [4] = '{24'h000000, 24'hFFFFFF, 24'hA5C30F, 24'h800001};
    int fails = 0;
    int num_checks = 0;

    always #5 clk = ~clk;

    adcpc_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_port_req(req), .i_pad_in(pad_in), .o_pad(pad), .o_port_in(port_in),
        .i_alt_clk(alt), .i_async_clk(asy), .i_conv_done(done), .i_conv_raw(raw), .o_conv_start(start),
        .o_conv_tick(tick), .o_conv_active(active), .o_async_osc_en(osc_en), .o_channel(chan),
        .o_mode(mode), .o_irq(irq));
    adcpc_port_model pm_u (.i_clk(clk), .i_rst_n(rst_n), .o_port_req(req), .o_pad_in(pad_in),
        .o_alt_clk(alt), .o_async_clk(asy));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // expected data is queued with its address; the monitor pops it a cycle later
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back({a, d});
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg

    always @(posedge clk) rd_seen <= rd;
    // read data stands only in the cycle after the strobe
    always @(negedge clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                chk("unexpected read", 1, 0);
            end else begin
                e = exp_q.pop_front();
                chk("rdata", {e[11:8], rdata}, e);
            end
        end
    end

    // rounding worked out independently of the block
    function automatic logic [11:0] rounded(input logic [1:0] m, input logic [11:0] r);
        logic [12:0] t;
        t = {1'b0, r};
        if (m == MODE_10) begin
            t = (t + 13'h0002) >> 2;
            return (t > 13'h03FF) ? 12'h3FF : t[11:0];
        end
        if (m == MODE_8) begin
            t = ({4'h0, r[8:0]} + 13'h0001) >> 1;
            return (t > 13'h00FF) ? 12'h0FF : t[11:0];
        end
        return r;
    endfunction : rounded

    task automatic pins(input logic [23:0] c);
        adcpc_pin_type p;
        logic [23:0] q;
        wr_reg(OFS_PIN_LO, c[7:0]);
        wr_reg(OFS_PIN_MID, c[15:8]);
        wr_reg(OFS_PIN_HI, c[23:16]);
        rd_reg(OFS_PIN_LO, c[7:0]);
        rd_reg(OFS_PIN_HI, c[23:16]);
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            p = req;
            q = pad_in;
            @(negedge clk);
            chk("pad oe", pad.oe, p.oe & ~c);
            chk("port in", port_in, q & ~c);
            chk("pull en", pad.pull_en, p.pull_en & ~c);
            chk("pad out", pad.out, p.out & ~c);
        end
    endtask : pins

    task automatic conv(input logic [1:0] m, input logic [7:0] ctl, input logic [11:0] r, input logic hit);
        logic [11:0] v;
        int n;
        v = rounded(m, r);
        wr_reg(OFS_CFG, {4'h0, m, 2'h0});
        wr_reg(OFS_CTRL, ctl);
        n = 0;
        while (start !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n >= 20) begin
            fails++;
            complete_run();
        end
        chk("channel", chan, ctl[4:0]);
        chk("mode", mode, m);
        @(posedge clk);
        done <= 1'b1;
        raw <= r;
        @(posedge clk);
        done <= 1'b0;
        raw <= ~r;
        if (hit) begin
            last_hi = {4'h0, v[11:8]};
            last_lo = v[7:0];
        end
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("irq", irq, hit & ctl[CTL_IRQ_EN]);
        chk("active after done", active, 0);
        rd_reg(OFS_STAT, {7'h00, hit});
        rd_reg(OFS_RES_HI, last_hi);
        rd_reg(OFS_RES_LO, last_lo);
    endtask : conv

    task automatic tick_period(input logic [1:0] sel, input logic [1:0] dv);
        int n;
        int per;
        per = (sel == CLK_BUS) ? 1 : (sel == CLK_BUS2) ? 2 : (sel == CLK_ALT) ? 4 : 8;
        per = per << dv;
        wr_reg(OFS_CFG, {1'b0, dv, 3'h0, sel}); // software stays in range
        wr_reg(OFS_CTRL, 8'h02);
        n = 0;
        while (tick !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            fails++;
            complete_run();
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tick !== 1'b1 && n < 200);
        chk("tick period", n, per);
        chk("async osc", osc_en, sel == CLK_ASYNC);
        rd_reg(OFS_STAT, 8'h02);
        wr_reg(OFS_CTRL, CH_OFF);
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            chk("start when off", start, 0);
        end
        chk("active when off", active, 0);
        chk("tick when off", tick, 0);
    endtask : tick_period

    initial begin
        #1000000;
        fails++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("channel at reset", chan, CH_OFF);
        rd_reg(OFS_PIN_LO, PIN_RST);
        rd_reg(OFS_PIN_MID, PIN_RST);
        rd_reg(OFS_PIN_HI, PIN_RST);
        rd_reg(OFS_CFG, CFG_RST);
        rd_reg(OFS_CTRL, CTRL_RST);
        rd_reg(4'hC, 8'h00);
        wr_reg(4'hC, 8'hFF);
        rd_reg(4'hC, 8'h00);
        foreach (pats[i]) pins(pats[i]);
        wr_reg(OFS_PIN_MID, 8'h3C);
        rd_reg(OFS_PIN_MID, 8'h3C);
        wr_reg(OFS_CMP_HI, 8'h02);
        wr_reg(OFS_CMP_LO, 8'h00);
        conv(MODE_12, 8'h40, 12'h123, 1'b1);
        conv(MODE_10, 8'h43, 12'hFFE, 1'b1);
        conv(MODE_10, 8'h05, 12'h7FD, 1'b1);
        conv(MODE_8, 8'h46, 12'hE05, 1'b1);
        conv(MODE_8, 8'h41, 12'h1FF, 1'b1);
        conv(MODE_12, 8'h60, 12'h300, 1'b0);
        conv(MODE_12, 8'hE0, 12'h300, 1'b1);
        conv(MODE_10, 8'h40, 12'h006, 1'b1);
        conv(MODE_10, 8'hE0, 12'h006, 1'b0);
        conv(MODE_8, 8'h60, 12'h0FF, 1'b0);
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 4; d++) tick_period(s[1:0], d[1:0]);
        end
        repeat (3) @(posedge clk);
        chk("reads left", exp_q.size(), 0);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
